// File: rtl/unit_id_defines.vh
`ifndef UNIT_ID_DEFINES_VH
`define UNIT_ID_DEFINES_VH
// ------------------------------------------------------------
// command codes from the network side
// ------------------------------------------------------------
`define CMD_SOFTWARE_RESET 16'h0004
`define CMD_EEPROM_PROTECT 16'h000a
`define CMD_EEPROM_PERMIT  16'h000b
`define CMD_EEPROM_STORE   16'h000c
`define CMD_EEPROM_LOAD    16'h000d
// ------------------------------------------------------------
// eeprom instruction bytes and values
// ------------------------------------------------------------
`define INS_WRITE_STATUS   8'h01
`define INS_WRITE_DATA     8'h02
`define INS_READ_DATA      8'h03
`define INS_WRITE_ENABLE   8'h06
`define STATUS_PROTECT     8'hfc
`define STATUS_PERMIT      8'hf0
`define EEPROM_BASE_ADDR   8'h00
`define UNIT_ID_BYTES      5'd16
`define GENERAL_REG_RESET  32'h0000_0000
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLOCK_MHZ          40
`define SELECT_GAP_NS      3200
`define SELECT_GAP_CYCLES  ((`SELECT_GAP_NS * `CLOCK_MHZ + 999) / 1000)
`define SCK_HALF_CYCLES    8
`endif

// File: rtl/spi_byte_shifter.v
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// one byte, mode 0, msb first; clock derived by a divider
// ------------------------------------------------------------
module spi_byte_shifter #(
  parameter HALF = 8
) (
  input  wire       i_clock,
  input  wire       i_rst,
  input  wire       i_ce,
  input  wire       i_start,
  input  wire [7:0] i_tx,
  input  wire       i_miso,
  output reg  [7:0] o_rx,
  output reg        o_done,
  output reg        o_sck,
  output reg        o_mosi
);
  reg [7:0] tx_r;
  reg [3:0] bits_r;
  reg [7:0] div_r;
  reg       busy_r;

  always @(posedge i_clock) begin
    if (i_rst) begin
      tx_r   <= 8'h00;
      bits_r <= 4'h0;
      div_r  <= 8'h00;
      busy_r <= 1'b0;
      o_rx   <= 8'h00;
      o_done <= 1'b0;
      o_sck  <= 1'b0;
      o_mosi <= 1'b0;
    end else if (i_ce) begin
      o_done <= 1'b0;
      if (!busy_r) begin
        if (i_start) begin
          busy_r <= 1'b1;
          tx_r   <= {i_tx[6:0], 1'b0};
          o_mosi <= i_tx[7];
          bits_r <= 4'h0;
          div_r  <= 8'h00;
        end
      end else if (div_r == HALF - 1) begin
        div_r <= 8'h00;
        o_sck <= ~o_sck;
        if (!o_sck) begin
          // sample on the rising edge; i_miso is already synchronised
          o_rx <= {o_rx[6:0], i_miso};
        end else begin
          if (bits_r == 4'h7) begin
            busy_r <= 1'b0;
            o_done <= 1'b1;
          end else begin
            o_mosi <= tx_r[7];
            tx_r   <= {tx_r[6:0], 1'b0};
          end
          bits_r <= bits_r + 4'h1;
        end
      end else begin
        div_r <= div_r + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/unit_id_eeprom_controller.v
// What this block does
// - eeprom operations start only while synchronised mode pin high
// - after reset copy unit id automatically
// - auto load after pin, software, broadcast reset
// - general registers reset to zero
// - eight bit address follows instruction byte
// - data moves as eight bit bytes
// - all sixteen bytes in one write
// - fixed instruction byte codes used
// - protect: enable, 3.2 us gap, write fc
// - permit: enable, 3.2 us gap, write f0
// - store: enable, gap, write sixteen bytes
// - load: read sixteen bytes from zero
// - network keeps stored device number meanwhile
// - registers readable as bytes, msb lowest
`timescale 1ns/1ps
`include "unit_id_defines.vh"
`default_nettype none
module unit_id_eeprom_controller #(
  parameter GAP_CYCLES = `SELECT_GAP_CYCLES,
  parameter SCK_HALF   = `SCK_HALF_CYCLES
) (
  input  wire         i_clock,
  input  wire         i_rst,
  input  wire         i_ce,
  input  wire         i_eeprom_mode_pin,
  input  wire         i_reset_event,
  input  wire         i_cmd_valid,
  input  wire [15:0]  i_cmd_code,
  input  wire         i_wr_valid,
  input  wire [1:0]   i_wr_index,
  input  wire [31:0]  i_wr_data,
  input  wire [3:0]   i_rd_addr,
  input  wire         i_eeprom_miso,
  output reg  [7:0]   o_rd_byte,
  output reg  [31:0]  o_general_reg_0,
  output reg  [31:0]  o_general_reg_1,
  output reg  [31:0]  o_general_reg_2,
  output reg  [31:0]  o_general_reg_3,
  output reg          o_busy,
  output reg          o_eeprom_select_n,
  output wire         o_eeprom_sck,
  output wire         o_eeprom_mosi
);
  // ----------------------------------------------------------
  // states
  // ----------------------------------------------------------
  localparam ST_IDLE = 3'd0;
  localparam ST_WREN = 3'd1;
  localparam ST_GAP  = 3'd2;
  localparam ST_INS  = 3'd3;
  localparam ST_ADDR = 3'd4;
  localparam ST_DATA = 3'd5;
  localparam ST_END  = 3'd6;

  localparam OP_PROTECT = 2'd0;
  localparam OP_PERMIT  = 2'd1;
  localparam OP_STORE   = 2'd2;
  localparam OP_LOAD    = 2'd3;

  reg [2:0]   state_r;
  reg [1:0]   op_r;
  reg [4:0]   count_r;
  reg [11:0]  gap_r;
  reg         start_r;
  reg [7:0]   tx_r;
  reg         mode_s1_r;
  reg         mode_r;
  reg         miso_s1_r;
  reg         miso_r;
  reg [127:0] id_r;
  reg         pending_load_r;
  wire [7:0]  rx_byte;
  wire        byte_done;

  // first flop only feeds the second
  always @(posedge i_clock) begin
    if (i_rst) begin
      mode_s1_r <= 1'b0;
      mode_r    <= 1'b0;
      miso_s1_r <= 1'b0;
      miso_r    <= 1'b0;
    end else if (i_ce) begin
      mode_s1_r <= i_eeprom_mode_pin;
      mode_r    <= mode_s1_r;
      miso_s1_r <= i_eeprom_miso;
      miso_r    <= miso_s1_r;
    end
  end

  spi_byte_shifter #(
    .HALF (SCK_HALF)
  ) u_shift (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_ce    (i_ce),
    .i_start (start_r),
    .i_tx    (tx_r),
    .i_miso  (miso_r),
    .o_rx    (rx_byte),
    .o_done  (byte_done),
    .o_sck   (o_eeprom_sck),
    .o_mosi  (o_eeprom_mosi)
  );

  // byte n of the id, byte 0 is the top of general_reg_0
  function [7:0] id_byte;
    input [127:0] id;
    input [3:0]   n;
    begin
      id_byte = id[127 - {n, 3'b000} -: 8];
    end
  endfunction

  always @* begin
    o_general_reg_0 = id_r[127:96];
    o_general_reg_1 = id_r[95:64];
    o_general_reg_2 = id_r[63:32];
    o_general_reg_3 = id_r[31:0];
  end

  // ----------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------
  always @(posedge i_clock) begin
    if (i_rst) begin
      state_r           <= ST_IDLE;
      op_r              <= OP_LOAD;
      count_r           <= 5'd0;
      gap_r             <= 12'd0;
      start_r           <= 1'b0;
      tx_r              <= 8'h00;
      id_r              <= {4{`GENERAL_REG_RESET}};
      pending_load_r    <= 1'b1;
      o_busy            <= 1'b0;
      o_eeprom_select_n <= 1'b1;
      o_rd_byte         <= 8'h00;
    end else if (i_ce) begin
      start_r   <= 1'b0;
      o_rd_byte <= id_byte(id_r, i_rd_addr);
      if (i_wr_valid && state_r == ST_IDLE) begin
        id_r[127 - {i_wr_index, 5'd0} -: 32] <= i_wr_data;
      end
      case (state_r)
        ST_IDLE: begin
          o_busy            <= 1'b0;
          o_eeprom_select_n <= 1'b1;
          if (mode_r) begin
            if (pending_load_r) begin
              pending_load_r <= 1'b0;
              op_r     <= OP_LOAD;
              state_r  <= ST_INS;
              tx_r     <= `INS_READ_DATA;
              start_r  <= 1'b1;
              o_busy   <= 1'b1;
              o_eeprom_select_n <= 1'b0;
            end else if (i_cmd_valid && i_cmd_code >= `CMD_EEPROM_PROTECT &&
                         i_cmd_code <= `CMD_EEPROM_LOAD) begin
              op_r    <= i_cmd_code[1:0] + 2'd2;
              o_busy  <= 1'b1;
              o_eeprom_select_n <= 1'b0;
              start_r <= 1'b1;
              if (i_cmd_code == `CMD_EEPROM_LOAD) begin
                state_r <= ST_INS;
                tx_r    <= `INS_READ_DATA;
              end else begin
                state_r <= ST_WREN;
                tx_r    <= `INS_WRITE_ENABLE;
              end
            end
          end
        end
        ST_WREN: begin
          if (byte_done) begin
            o_eeprom_select_n <= 1'b1;
            gap_r   <= 12'd0;
            state_r <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (gap_r == GAP_CYCLES - 1) begin
            o_eeprom_select_n <= 1'b0;
            start_r <= 1'b1;
            state_r <= ST_INS;
            tx_r <= (op_r == OP_STORE) ? `INS_WRITE_DATA : `INS_WRITE_STATUS;
          end else begin
            gap_r <= gap_r + 12'd1;
          end
        end
        ST_INS: begin
          if (byte_done) begin
            start_r <= 1'b1;
            count_r <= 5'd0;
            if (op_r == OP_PROTECT || op_r == OP_PERMIT) begin
              tx_r    <= (op_r == OP_PROTECT) ? `STATUS_PROTECT : `STATUS_PERMIT;
              state_r <= ST_END;
            end else begin
              tx_r    <= `EEPROM_BASE_ADDR;
              state_r <= ST_ADDR;
            end
          end
        end
        ST_ADDR: begin
          if (byte_done) begin
            start_r <= 1'b1;
            tx_r    <= id_byte(id_r, 4'd0);
            state_r <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (byte_done) begin
            if (op_r == OP_LOAD) begin
              id_r[127 - {count_r[3:0], 3'b000} -: 8] <= rx_byte;
            end
            if (count_r == `UNIT_ID_BYTES - 5'd1) begin
              o_eeprom_select_n <= 1'b1;
              state_r <= ST_IDLE;
            end else begin
              count_r <= count_r + 5'd1;
              tx_r    <= id_byte(id_r, count_r[3:0] + 4'd1);
              start_r <= 1'b1;
            end
          end
        end
        ST_END: begin
          if (byte_done) begin
            o_eeprom_select_n <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
      // reset events rearm load; placed last so a new event beats the clear
      if (i_reset_event || (i_cmd_valid && i_cmd_code == `CMD_SOFTWARE_RESET)) begin
        pending_load_r <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/eeprom_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// serial eeprom stand-in, mode 0, no write delay modelled
// ------------------------------------------------------------
module eeprom_model (
  input  wire logic i_sel_n,
  input  wire logic i_sck,
  input  wire logic i_mosi,
  output logic      o_miso
);
  logic [7:0] mem [16];
  logic [7:0] sh, ins, adr, st, rd;
  logic       wel, last, wp_n;
  int         n;
  initial begin
    st = 8'h00;
    wel = 1'b0;
    wp_n = 1'b1;
    last = 1'b0;
    rd = 8'h00;
  end
  // released line shows the inverse, so a stale bit never looks valid
  assign o_miso = i_sel_n ? ~last : rd[7];
  always @(negedge i_sel_n) n = 0;
  always @(posedge i_sck) if (!i_sel_n) begin
    sh = {sh[6:0], i_mosi};
    n++;
    if (n == 8) ins = sh;
    if (n == 8 && sh == 8'h06) wel = 1'b1;
    if (n == 16 && ins != 8'h01) adr = sh;
    if (n >= 16 && n % 8 == 0 && ins == 8'h03) begin
      rd = mem[adr[3:0]];
      adr++;
    end
    if (n == 16 && ins == 8'h01 && wel && wp_n) st = sh;
    if (n > 16 && n % 8 == 0 && ins == 8'h02 && wel && st[3:2] == 2'b00) begin
      mem[adr[3:0]] = sh;
      adr++;
    end
  end
  always @(negedge i_sck) if (!i_sel_n) begin
    last = rd[7];
    if (n % 8 != 0) rd = {rd[6:0], 1'b0};
  end
  always @(posedge i_sel_n) if (n >= 16 && ins inside {8'h01, 8'h02}) wel = 1'b0;
endmodule
`default_nettype wire

// File: verif/unit_id_eeprom_controller_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module unit_id_eeprom_controller_monitor #(
  parameter GAP_CYCLES = 128
) (
  input wire logic        i_clock,
  input wire logic        i_rst,
  input wire logic        i_ce,
  input wire logic        i_eeprom_mode_pin,
  input wire logic        i_reset_event,
  input wire logic [3:0]  i_rd_addr,
  input wire logic [7:0]  o_rd_byte,
  input wire logic [31:0] o_general_reg_0,
  input wire logic [31:0] o_general_reg_1,
  input wire logic [31:0] o_general_reg_2,
  input wire logic [31:0] o_general_reg_3,
  input wire logic        o_busy,
  input wire logic        o_eeprom_select_n,
  input wire logic        o_eeprom_sck,
  input wire logic        o_eeprom_mosi
);
  logic [15:0]  hi_cnt;
  logic [7:0]   bit_cnt, exp_r;
  logic         wren_r;
  wire  [127:0] flat = {o_general_reg_0, o_general_reg_1, o_general_reg_2, o_general_reg_3};
  always @(posedge i_clock) begin
    if (i_ce) exp_r <= flat[8*(15-i_rd_addr) +: 8];
    // only a select that ended a lone 8-bit byte opens a timed gap
    if (i_rst) wren_r <= 1'b0;
    else if ($rose(o_eeprom_select_n)) wren_r <= (bit_cnt == 8'h08);
    if (i_rst || !o_eeprom_select_n) hi_cnt <= 16'h0000;
    else if (hi_cnt != 16'hffff) hi_cnt <= hi_cnt + 16'h0001;
    if (o_eeprom_select_n) bit_cnt <= 8'h00;
    else if ($rose(o_eeprom_sck)) bit_cnt <= bit_cnt + 8'h01;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  a_mode_gates_traffic: assert property (
    !i_eeprom_mode_pin && !$past(i_eeprom_mode_pin) && !$past(i_eeprom_mode_pin, 2) && !o_busy
    |=> !o_busy) else $error("operation began with mode pin low");
  a_event_starts_load: assert property (
    i_reset_event && !o_busy && $past(i_eeprom_mode_pin) && $past(i_eeprom_mode_pin, 2)
    |-> ##[1:6] o_busy) else $error("no load after reset event");
  a_regs_reset_zero: assert property (
    $past(i_rst) |-> flat == 128'h0) else $error("general registers not zero after reset");
  a_gap_length: assert property (
    $fell(o_eeprom_select_n) && wren_r |-> hi_cnt >= GAP_CYCLES) else $error("select gap short");
  a_whole_bytes: assert property (
    $rose(o_eeprom_select_n) |-> bit_cnt != 8'h00 && bit_cnt[2:0] == 3'h0)
    else $error("select released mid byte");
  a_sck_selected: assert property (
    o_eeprom_sck |-> !o_eeprom_select_n) else $error("clock pulse while deselected");
  a_mosi_held: assert property (
    o_eeprom_sck |-> $stable(o_eeprom_mosi)) else $error("data moved while clock high");
  a_busy_select: assert property (
    $changed(o_busy) |-> o_eeprom_select_n == !o_busy) else $error("busy and select disagree");
  a_byte_map: assert property (
    !$past(i_rst) |-> o_rd_byte == exp_r) else $error("read byte mismatch");
endmodule
bind unit_id_eeprom_controller unit_id_eeprom_controller_monitor #(
  .GAP_CYCLES(GAP_CYCLES)) mon_u (.*);
`default_nettype wire

// File: verif/unit_id_eeprom_controller_tb.sv
`timescale 1ns/1ps
`include "unit_id_defines.vh"
`default_nettype none
module unit_id_eeprom_controller_tb;
  logic        i_clock = 0, i_rst = 1, i_ce = 1, i_eeprom_mode_pin = 1, i_reset_event = 0;
  logic        i_cmd_valid = 0, i_wr_valid = 0, i_eeprom_miso;
  logic [15:0] i_cmd_code = 16'h0000;
  logic [1:0]  i_wr_index = 2'h0;
  logic [31:0] i_wr_data = 32'h0000_0000;
  logic [3:0]  i_rd_addr = 4'h0;
  logic [7:0]  o_rd_byte;
  logic [31:0] o_general_reg_0, o_general_reg_1, o_general_reg_2, o_general_reg_3;
  logic        o_busy, o_eeprom_select_n, o_eeprom_sck, o_eeprom_mosi;
  int          miscompares = 0, checks = 0, cyc = 0;
  wire [127:0] regs = {o_general_reg_0, o_general_reg_1, o_general_reg_2, o_general_reg_3};
  logic [127:0] exp = 128'ha0a1a2a3_b0b1b2b3_c0c1c2c3_d0d1d2d3;
  unit_id_eeprom_controller dut_u (.*);
  eeprom_model m_u (.i_sel_n(o_eeprom_select_n), .i_sck(o_eeprom_sck),
    .i_mosi(o_eeprom_mosi), .o_miso(i_eeprom_miso));
  always #12.5 i_clock = ~i_clock;
  // a whole run needs about 19000 cycles
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [127:0] got, input logic [127:0] want);
    checks++;
    if (got !== want) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  function automatic logic [127:0] mem_flat();
    for (int i = 0; i < 16; i++) mem_flat[127-8*i -: 8] = m_u.mem[i];
  endfunction
  task automatic wait_op();
    @(negedge i_clock);
    repeat (20) if (o_busy !== 1'b1) @(negedge i_clock);
    repeat (6000) if (o_busy !== 1'b0) @(negedge i_clock);
    chk(o_busy, 1'b0);
    repeat (40) @(negedge i_clock);
  endtask
  task automatic send(input logic [15:0] code);
    @(posedge i_clock);
    i_cmd_valid <= 1'b1;
    i_cmd_code <= code;
    @(posedge i_clock);
    i_cmd_valid <= 1'b0;
    wait_op();
  endtask
  task automatic wr(input logic [1:0] idx, input logic [31:0] d);
    @(posedge i_clock);
    i_wr_valid <= 1'b1;
    i_wr_index <= idx;
    i_wr_data <= d;
    @(posedge i_clock);
    i_wr_valid <= 1'b0;
  endtask
  task automatic t_autoload();
    chk(regs, 128'h0);
    wait_op();
    chk(regs, mem_flat());
    $display("test autoload done");
  endtask
  task automatic t_reload();
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 16; i++) m_u.mem[i] = 8'h40 + 8'(16 * k + i);
      if (k == 0) begin
        @(posedge i_clock);
        i_reset_event <= 1'b1;
        @(posedge i_clock);
        i_reset_event <= 1'b0;
        wait_op();
      end else send(k == 1 ? `CMD_SOFTWARE_RESET : `CMD_EEPROM_LOAD);
      chk(regs, mem_flat());
    end
    $display("test reload done");
  endtask
  task automatic t_mode();
    logic [127:0] held;
    held = regs;
    for (int i = 0; i < 16; i++) m_u.mem[i] = 8'hee;
    @(posedge i_clock);
    i_eeprom_mode_pin <= 1'b0;
    repeat (4) @(posedge i_clock);
    send(`CMD_EEPROM_LOAD);
    chk(o_busy, 1'b0);
    chk(regs, held);
    @(posedge i_clock);
    i_eeprom_mode_pin <= 1'b1;
    repeat (4) @(posedge i_clock);
    $display("test mode pin done");
  endtask
  task automatic t_store();
    send(`CMD_EEPROM_PERMIT);
    chk(m_u.st, `STATUS_PERMIT);
    for (int i = 0; i < 4; i++) wr(2'(i), exp[127-32*i -: 32]);
    @(negedge i_clock);
    chk(regs, exp);
    send(`CMD_EEPROM_STORE);
    chk(mem_flat(), exp);
    m_u.wp_n = 1'b0;
    send(`CMD_EEPROM_PROTECT);
    chk(m_u.st, `STATUS_PERMIT);
    m_u.wp_n = 1'b1;
    send(`CMD_EEPROM_PROTECT);
    chk(m_u.st, `STATUS_PROTECT);
    wr(2'h3, 32'h5a5a_5a5a);
    send(`CMD_EEPROM_STORE);
    chk(mem_flat(), exp);
    $display("test store done");
  endtask
  task automatic t_read();
    exp[31:0] = 32'h5a5a_5a5a;
    for (int a = 0; a < 16; a++) begin
      @(posedge i_clock);
      i_rd_addr <= 4'(a);
      @(posedge i_clock);
      @(negedge i_clock);
      chk(o_rd_byte, exp[127-8*a -: 8]);
    end
    $display("test byte read done");
  endtask
  task automatic t_freeze();
    logic [3:0] snap;
    @(posedge i_clock);
    i_cmd_valid <= 1'b1;
    i_cmd_code <= `CMD_EEPROM_LOAD;
    @(posedge i_clock);
    i_cmd_valid <= 1'b0;
    repeat (300) @(posedge i_clock);
    i_ce <= 1'b0;
    repeat (2) @(negedge i_clock);
    snap = {o_busy, o_eeprom_select_n, o_eeprom_sck, o_eeprom_mosi};
    repeat (50) begin
      @(negedge i_clock);
      chk({o_busy, o_eeprom_select_n, o_eeprom_sck, o_eeprom_mosi}, snap);
    end
    @(posedge i_clock);
    i_ce <= 1'b1;
    wait_op();
    chk(regs, mem_flat());
    $display("test clock enable done");
  endtask
  initial begin
    for (int i = 0; i < 16; i++) m_u.mem[i] = 8'h10 + 8'(i);
    repeat (6) @(posedge i_clock);
    i_rst <= 1'b0;
    t_autoload();
    t_reload();
    t_mode();
    t_store();
    t_read();
    t_freeze();
    summarize();
  end
endmodule
`default_nettype wire
